// >>> usm_pkg.sv
// usm_pkg: shared constants and types for the serial master in spi mode
// assumes: one system clock, synchronous active-high reset
package usm_pkg;

   // ------------------------------------------------------------
   // frame and divisor layout
   // ------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 8;    // data bits per frame
   localparam int unsigned DIV_W      = 12;   // baud divisor width
   localparam int unsigned BIT_IDX_W  = 3;    // bit index width
   localparam int unsigned RX_LEVELS  = 2;    // receive buffer levels
   localparam int unsigned RX_CNT_W   = 2;    // receive level counter

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [11:0] BAUD_RESET = 12'h000;  // divisor after reset
   localparam logic [2:0]  LAST_BIT   = 3'h7;     // index of last bit
   localparam logic [1:0]  MODE_MSPI  = 2'h3;     // mode pair for spi
   localparam logic        LINE_IDLE  = 1'h1;     // idle data line level

   // ------------------------------------------------------------
   // transfer states
   // ------------------------------------------------------------
   typedef enum logic [0:0] {
      USM_IDLE,
      USM_SHIFT
   } usm_state_e;

endpackage

// >>> usm_baud.sv
// usm_baud: half-period tick generator for the transfer clock
// assumes: run low while no frame shifts, divisor stable during a frame
module usm_baud #(
   parameter int unsigned W = usm_pkg::DIV_W
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         run,        // count only while shifting
   input  wire logic [W-1:0] divisor,    // half period is divisor+1
   output logic              tick        // one pulse per half period
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt;                 // cycles into half period
      logic         tick;                // registered tick
   } usm_baud_s;

   usm_baud_s st_reg;                    // current state
   usm_baud_s st_next;                   // next state

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // restart from zero when idle so a transfer starts with a full half period
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (!run) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt == divisor) begin     // RL6 RL7
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;

endmodule

// >>> usm_master.sv
// usm_master: serial unit run as a three-wire spi master
// assumes: software strobes are one-cycle pulses on sys_clk,
// serial input pin is asynchronous and is synchronised here
//
// Contract
// [RL1] mode pair 11 selects spi master
// [RL2] no parity, recovery; one shared controller
// [RL3] pin control and locations unchanged
// [RL4] internal clock only; pin must be output
// [RL5] set clock pin output before enabling
// [RL6] clock is sysclk over 2(divisor+1)
// [RL7] divisor zero gives half system clock
// [RL8] polarity and phase select modes 0-3
// [RL9] setup and sample on opposite edges
// [RL10] do not change mode mid transfer
// [RL11] eight bits, msb or lsb first
// [RL12] receive and transmit share data order
// [RL13] next frame back to back or idle-high
// [RL14] double buffered; complete after both bytes
// [RL15] receiver needs transmitter enabled
// [RL16] divisor zero at enable, then write
// [RL17] baud divisor resets to zero
// [RL18] idle before reconfig; clear complete flag
// [RL19] buffer write starts every transfer
// [RL20] overflow drops newest received byte
// [RL21] error flags always read zero
// [RL22] idle clock at polarity level
// [RL23] set receive and transmit complete flags
module usm_master (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [1:0]  mode_select_pair,      // 11 selects spi
   input  wire logic        clock_polarity_bit,    // idle clock level
   input  wire logic        clock_phase_bit,       // sample on trailing
   input  wire logic        data_order_bit,        // 1 lsb first
   input  wire logic        transmitter_enable_bit,
   input  wire logic        receiver_enable_bit,
   input  wire logic        clock_pin_direction,   // 1 pin is output
   input  wire logic        baud_wr,               // divisor write
   input  wire logic [11:0] baud_wdata,            // divisor value
   input  wire logic        data_wr,               // data buffer write
   input  wire logic [7:0]  data_wdata,            // byte to send
   input  wire logic        data_rd,               // data buffer read
   input  wire logic        tx_complete_clr,       // clear tx complete
   input  wire logic        serial_in,             // pin, asynchronous
   output logic [7:0]       data_rdata,            // oldest unread byte
   output logic [11:0]      baud_divisor,          // current divisor
   output logic             master_spi_mode,       // spi mode active
   output logic             data_empty_flag,       // tx buffer empty
   output logic             transmit_complete_flag,
   output logic             receive_complete_flag,
   output logic             frame_error_flag,      // unused, zero
   output logic             data_overrun_flag,     // unused, zero
   output logic             parity_error_flag,     // unused, zero
   output logic             transfer_clock_out,    // clock pin level
   output logic             transfer_clock_oe,     // clock pin drive
   output logic             serial_out,            // data pin level
   output logic             serial_out_oe          // data pin drive
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      usm_pkg::usm_state_e  state;      // idle or shifting
      logic [11:0]          baud;       // baud divisor
      logic [7:0]           tx_buf;     // queued byte
      logic                 tx_full;    // queued byte present
      logic [7:0]           tx_sh;      // byte being shifted
      logic [7:0]           rx_sh;      // byte being assembled
      logic [2:0]           bit_idx;    // bit within frame
      logic                 half;       // 1 after leading edge
      logic                 sck;        // clock pin level
      logic                 mosi;       // data pin level
      logic                 txc;        // transmit complete
      logic [7:0]           rx_buf0;    // oldest unread byte
      logic [7:0]           rx_buf1;    // second unread byte
      logic [1:0]           rx_cnt;     // unread bytes held
      logic                 in_meta;    // synchroniser stage 1
      logic                 in_sync;    // synchroniser stage 2
   } usm_master_s;

   usm_master_s st_reg;                 // current state
   usm_master_s st_next;                // next state
   logic        tick;                   // half period elapsed
   logic        active;                 // spi master enabled
   logic        rx_on;                  // receiver enabled

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // position of frame bit n in the byte, from the shared order
   function automatic logic [2:0] bit_pos(input logic [2:0] n,
                                          input logic       lsb);
      bit_pos = lsb ? n : (usm_pkg::LAST_BIT - n);   // RL11 RL12
   endfunction

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   // spi master only with the pair set, clock pin out, tx enabled
   assign active = (mode_select_pair == usm_pkg::MODE_MSPI)  // RL1
                   && clock_pin_direction                     // RL4
                   && transmitter_enable_bit;
   assign rx_on  = active && receiver_enable_bit;             // RL15

   // ------------------------------------------------------------
   // half-period generator
   // ------------------------------------------------------------
   usm_baud #(
      .W       (usm_pkg::DIV_W)
   ) u_baud (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (st_reg.state == usm_pkg::USM_SHIFT),
      .divisor (st_reg.baud),
      .tick    (tick)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // one shared controller replaces separate rx and tx control
   always_comb begin
      logic       sample;               // sample the input now
      logic       frame_end;            // last trailing edge now
      logic [7:0] got;                  // completed received byte
      logic       load;                 // move buffer to shifter
      sample    = 1'b0;
      frame_end = 1'b0;
      got       = st_reg.rx_sh;
      load      = 1'b0;
      st_next   = st_reg;

      // input pin synchroniser
      st_next.in_meta = serial_in;
      st_next.in_sync = st_reg.in_meta;

      // divisor write
      if (baud_wr) begin
         st_next.baud = baud_wdata;
      end

      // software clear of transmit complete
      if (tx_complete_clr) begin
         st_next.txc = 1'b0;
      end

      // data buffer write queues a byte and starts transfers
      if (data_wr && active && !st_reg.tx_full) begin   // RL19 RL14
         st_next.tx_buf  = data_wdata;
         st_next.tx_full = 1'b1;
      end

      // data buffer read pops the oldest byte
      if (data_rd && st_reg.rx_cnt != 2'h0) begin
         st_next.rx_buf0 = st_reg.rx_buf1;
         st_next.rx_cnt  = st_reg.rx_cnt - 2'h1;
      end

      unique case (st_reg.state)
         usm_pkg::USM_IDLE: begin
            st_next.sck  = clock_polarity_bit;          // RL22
            st_next.mosi = usm_pkg::LINE_IDLE;          // RL13
            load = active && st_reg.tx_full;
         end
         usm_pkg::USM_SHIFT: begin
            if (tick && !st_reg.half) begin
               // leading edge
               st_next.sck  = ~st_reg.sck;
               st_next.half = 1'b1;
               if (clock_phase_bit) begin                // RL8 RL9
                  st_next.mosi = st_reg.tx_sh[bit_pos(st_reg.bit_idx,
                                              data_order_bit)];
               end else begin
                  sample = 1'b1;
               end
            end else if (tick) begin
               // trailing edge
               st_next.sck     = ~st_reg.sck;
               st_next.half    = 1'b0;
               st_next.bit_idx = st_reg.bit_idx + 3'h1;
               if (clock_phase_bit) begin                // RL8 RL9
                  sample = 1'b1;
               end else if (st_reg.bit_idx != usm_pkg::LAST_BIT) begin
                  st_next.mosi = st_reg.tx_sh[bit_pos(
                                 st_reg.bit_idx + 3'h1, data_order_bit)];
               end
               frame_end = (st_reg.bit_idx == usm_pkg::LAST_BIT);  // RL11
            end
         end
      endcase

      // sampled bit lands at its ordered position
      if (sample) begin
         got[bit_pos(st_reg.bit_idx, data_order_bit)] = st_reg.in_sync;
         st_next.rx_sh = got;
      end

      // frame end: store, then chain or go idle
      if (frame_end) begin
         if (rx_on) begin
            // a full buffer drops this newest byte
            if (st_reg.rx_cnt == 2'h0 ||
                (data_rd && st_reg.rx_cnt == 2'h1)) begin  // RL20
               st_next.rx_buf0 = got;
            end else if (st_reg.rx_cnt == 2'h1 ||
                         data_rd) begin                    // RL20
               st_next.rx_buf1 = got;
            end
            if (st_reg.rx_cnt != 2'(usm_pkg::RX_LEVELS) || data_rd) begin
               st_next.rx_cnt = st_next.rx_cnt + 2'h1;     // RL23
            end
         end
         if (active && st_reg.tx_full) begin
            load = 1'b1;                                   // RL13
         end else begin
            st_next.state = usm_pkg::USM_IDLE;
            // phase one samples on this edge: data idles a cycle later
            if (!clock_phase_bit) begin                    // RL9
               st_next.mosi = usm_pkg::LINE_IDLE;          // RL13
            end
            st_next.txc   = 1'b1;                          // RL14 RL23
         end
      end

      // move the queued byte into the shifter
      if (load) begin
         st_next.state   = usm_pkg::USM_SHIFT;
         st_next.tx_sh   = st_reg.tx_buf;
         st_next.tx_full = (data_wr && st_reg.tx_full) ? 1'b1 : 1'b0;
         if (data_wr && st_reg.tx_full) begin
            st_next.tx_buf = data_wdata;
         end
         st_next.bit_idx = 3'h0;
         st_next.half    = 1'b0;
         st_next.sck     = clock_polarity_bit;             // RL22
         st_next.rx_sh   = 8'h00;
         if (!clock_phase_bit) begin                       // RL9
            st_next.mosi = st_reg.tx_buf[bit_pos(3'h0, data_order_bit)];
         end
      end

      // disabling transmitter aborts, disabling receiver flushes
      if (!active) begin
         st_next.state   = usm_pkg::USM_IDLE;
         st_next.tx_full = 1'b0;
         st_next.sck     = clock_polarity_bit;             // RL22
         st_next.mosi    = usm_pkg::LINE_IDLE;
      end
      if (!rx_on) begin
         st_next.rx_cnt = 2'h0;                            // RL15
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg       <= '0;
         st_reg.baud  <= usm_pkg::BAUD_RESET;              // RL17
         st_reg.mosi  <= usm_pkg::LINE_IDLE;
         st_reg.state <= usm_pkg::USM_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign data_rdata             = st_reg.rx_buf0;
   assign baud_divisor           = st_reg.baud;
   assign master_spi_mode        = active;
   assign data_empty_flag        = !st_reg.tx_full;
   assign transmit_complete_flag = st_reg.txc;
   assign receive_complete_flag  = (st_reg.rx_cnt != 2'h0);  // RL23
   assign frame_error_flag       = 1'b0;                     // RL21 RL2
   assign data_overrun_flag      = 1'b0;                     // RL21
   assign parity_error_flag      = 1'b0;                     // RL21 RL2
   // pin control behaves as in normal serial mode
   assign transfer_clock_out     = st_reg.sck;
   assign transfer_clock_oe      = clock_pin_direction;      // RL3 RL4
   assign serial_out             = st_reg.mosi;
   assign serial_out_oe          = active;                   // RL3

endmodule

// >>> usm_checker.sv
// usm_checker: port-level assertions for the spi master
// assumes: bound to usm_master, one clock, synchronous reset
module usm_checker (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [1:0]  mode_select_pair,
   input wire logic        clock_polarity_bit,
   input wire logic        clock_phase_bit,
   input wire logic        transmitter_enable_bit,
   input wire logic        clock_pin_direction,
   input wire logic        data_wr,
   input wire logic        tx_complete_clr,
   input wire logic [11:0] baud_divisor,
   input wire logic        master_spi_mode,
   input wire logic        data_empty_flag,
   input wire logic        transmit_complete_flag,
   input wire logic        frame_error_flag,
   input wire logic        data_overrun_flag,
   input wire logic        parity_error_flag,
   input wire logic        transfer_clock_out,
   input wire logic        transfer_clock_oe,
   input wire logic        serial_out,
   input wire logic        serial_out_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------
   // half-period counter
   // ---------------------------------------------------------
   logic        last_clk_reg;   // clock pin one cycle ago
   logic [12:0] half_reg;       // cycles since the pin last moved
   wire         moved = transfer_clock_out != last_clk_reg;
   // restarts on each pin move, saturates while idle
   always_ff @(posedge sys_clk) begin
      last_clk_reg <= transfer_clock_out;
      if (sys_rst || moved)
         half_reg <= 13'h0000;
      else if (half_reg != 13'h1fff)
         half_reg <= half_reg + 13'h0001;
   end
   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   sequence s_take;   // accepted buffer write
      data_wr && master_spi_mode && data_empty_flag;
   endsequence
   sequence s_done;   // all queued bytes shifted out
      $rose(transmit_complete_flag);
   endsequence
   AST_NO_ERR: assert property (
      !frame_error_flag && !data_overrun_flag && !parity_error_flag)
      else $error("error flag set in spi mode");
   AST_MODE: assert property (master_spi_mode ==
      (mode_select_pair == usm_pkg::MODE_MSPI && clock_pin_direction
       && transmitter_enable_bit))
      else $error("spi mode does not follow its enables");
   AST_CLK_OE: assert property (
      transfer_clock_oe == clock_pin_direction)
      else $error("clock pin drive differs from direction");
   AST_DATA_OE: assert property (serial_out_oe == master_spi_mode)
      else $error("data pin drive differs from mode");
   AST_TAKE: assert property (s_take |=> !data_empty_flag)
      else $error("accepted write left buffer empty");
   AST_IDLE: assert property (s_done |->
      transfer_clock_out == clock_polarity_bit
      && (clock_phase_bit || serial_out == usm_pkg::LINE_IDLE))
      else $error("lines not idle at transfer end");
   AST_IDLE_DATA: assert property (s_done ##0 clock_phase_bit |=>
      serial_out == usm_pkg::LINE_IDLE)
      else $error("data line not idle after phase one transfer");
   AST_HALF: assert property (moved && master_spi_mode &&
      clock_polarity_bit == $past(clock_polarity_bit, 2)
      |-> half_reg >= {1'b0, baud_divisor})
      else $error("clock half period shorter than divisor");
   AST_CLR: assert property (tx_complete_clr &&
      transmit_complete_flag && data_empty_flag |=> !transmit_complete_flag)
      else $error("transmit complete not cleared");
endmodule
bind usm_master usm_checker chk (.*);

// >>> usm_spi_slave_model.sv
// usm_spi_slave_model: behavioural spi slave on the far side
// assumes: load pulses before each burst, bursts of up to two bytes
module usm_spi_slave_model (
   input  wire logic        sck,      // transfer clock from master
   input  wire logic        mosi,     // master data out
   input  wire logic        cpol,
   input  wire logic        cpha,
   input  wire logic        lsb,
   input  wire logic        load,     // starts a burst
   input  wire logic [15:0] tx_w,     // low byte goes first
   output logic             miso,
   output logic [15:0]      rx_w,     // bytes seen from master
   output int               frames,
   output longint           span_ns   // first to last edge of burst
);
   timeunit 1ns;
   timeprecision 1ns;
   int     e = 0;   // clock edges seen in burst
   int     n;       // next bit to send
   longint t0;
   // bit position inside a byte for the shared data order
   function automatic int pos(input int b);
      return b / 8 * 8 + (lsb ? b % 8 : 7 - b % 8);
   endfunction
   initial begin
      miso = 1'b0;
      frames = 0;
      span_ns = 0;
      rx_w = 16'h0000;
   end
   always @(posedge load) begin
      e = 0;
      frames = 0;
      miso = cpha ? ~miso : tx_w[pos(0)];
   end
   // sample on one edge, set up on the other
   always @(sck) begin
      if (e < 32) begin
         if (e == 0) t0 = $time;
         e++;
         n = cpha ? (e - 1) / 2 : e / 2;
         if ((sck != cpol) ^ cpha)
            rx_w[pos((e - 1) / 2)] = mosi;
         else
            miso = n < 16 ? tx_w[pos(n)] : ~miso;   // released pin
         if (e % 16 == 0) begin
            frames++;
            span_ns = $time - t0;
         end
      end
   end
endmodule

// >>> usm_master_bench.sv
// usm_master_bench: self-checking random bench for the spi master
// assumes: design, checker and slave model compiled before it
module usm_master_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, baud_wr = 1'b0;
   logic        clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
   logic        data_order_bit = 1'b0, transmitter_enable_bit = 1'b1;
   logic        receiver_enable_bit = 1'b1, clock_pin_direction = 1'b1;
   logic        data_wr = 1'b0, data_rd = 1'b0, tx_complete_clr = 1'b0;
   logic        load = 1'b0, serial_in;
   logic [1:0]  mode_select_pair = 2'h3;
   logic [11:0] baud_wdata = 12'h000, baud_divisor;
   logic [7:0]  data_wdata = 8'h00, data_rdata;
   logic [15:0] tx_w = 16'h0000, rx_w;
   logic        master_spi_mode, data_empty_flag, transmit_complete_flag;
   logic        receive_complete_flag, frame_error_flag, data_overrun_flag;
   logic        parity_error_flag, transfer_clock_out, transfer_clock_oe;
   logic        serial_out, serial_out_oe;
   int          fail_count = 0, checks = 0, cyc = 0, frames;
   longint      span_ns;
   usm_master dut (.*);
   usm_spi_slave_model slave (.sck(transfer_clock_out), .mosi(serial_out),
      .cpol(clock_polarity_bit), .cpha(clock_phase_bit),
      .lsb(data_order_bit), .load(load), .tx_w(tx_w), .miso(serial_in),
      .rx_w(rx_w), .frames(frames), .span_ns(span_ns));
   initial forever #10 sys_clk = ~sys_clk;
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(ref logic s);   // one-cycle strobe
      @(negedge sys_clk) s = 1'b1;
      @(negedge sys_clk) s = 1'b0;
   endtask
   task automatic wait_for(ref logic s, input int lim);
      int k;
      for (k = 0; k < lim && s !== 1'b1; k++) @(negedge sys_clk);
      if (k == lim) chk("wait", 16'h0001, 16'h0000);
   endtask
   // first to last clock edge of a burst in ns
   function automatic logic [15:0] exp_span(int nb, logic [11:0] div);
      return 16'((16 * nb - 1) * (div + 1) * 20);
   endfunction
   task automatic cfg(logic [2:0] m, logic [11:0] div);
      repeat (20) @(negedge sys_clk);   // idle before reconfig
      {clock_polarity_bit, clock_phase_bit, data_order_bit} = m;
      baud_wdata = div;
      pulse(baud_wr);
   endtask
   task automatic xfer(int nb, bit rd, logic [11:0] div);
      logic [15:0] w;
      w = 16'($urandom);
      tx_w = 16'($urandom);
      pulse(tx_complete_clr);
      load = 1'b1;
      data_wdata = w[7:0];
      pulse(data_wr);
      load = 1'b0;
      if (nb == 2) begin
         @(negedge sys_clk);
         wait_for(data_empty_flag, 200);
         data_wdata = w[15:8];
         pulse(data_wr);
      end
      wait_for(transmit_complete_flag, 3000);
      chk("frames", 16'(nb), 16'(frames));
      chk("mosi", nb == 2 ? w : w & 16'h00ff,
          nb == 2 ? rx_w : rx_w & 16'h00ff);
      chk("span", exp_span(nb, div), span_ns[15:0]);
      chk("idle clock", 16'(clock_polarity_bit),
          16'(transfer_clock_out));
      repeat (2) @(negedge sys_clk);
      chk("idle data", 16'h0001, 16'(serial_out));
      if (rd) begin
         chk("rx flag", 16'(receiver_enable_bit),
             16'(receive_complete_flag));
         for (int k = 0; k < nb && receiver_enable_bit; k++) begin
            if (div > 1) chk("miso", tx_w[8*k +: 8], data_rdata);
            pulse(data_rd);
            @(negedge sys_clk);
         end
         chk("rx empty", 16'h0000, 16'(receive_complete_flag));
      end
   endtask
   initial begin
      logic [7:0]  ov [3];
      logic [11:0] div;
      void'($urandom(5));
      repeat (8) @(negedge sys_clk);
      sys_rst = 1'b0;
      @(negedge sys_clk);
      chk("reset divisor", 16'h0000, 16'(baud_divisor));
      chk("reset flags", 16'h0003, 16'({transmit_complete_flag,
          receive_complete_flag, frame_error_flag, data_overrun_flag,
          parity_error_flag, data_empty_flag, serial_out}));
      // writes outside mode must be ignored
      mode_select_pair = 2'h1;
      pulse(data_wr);
      mode_select_pair = 2'h3;
      clock_pin_direction = 1'b0;
      pulse(data_wr);
      repeat (100) @(negedge sys_clk);
      chk("refused", 16'h0000, 16'({master_spi_mode,
          transmit_complete_flag, receive_complete_flag}));
      clock_pin_direction = 1'b1;
      // all four modes in both orders, divisors 0-3 then random
      for (int i = 0; i < 8; i++) begin
         div = i < 4 ? 12'(i) : 12'(2 + $urandom % 5);
         receiver_enable_bit = (i != 6);
         cfg(3'(i % 4 * 2 + i / 4), div);
         xfer(1 + i % 2, 1'b1, div);
      end
      // three bytes unread: the newest is dropped
      cfg(3'h0, 12'h003);
      for (int k = 0; k < 3; k++) begin
         xfer(1, 1'b0, 12'h003);
         ov[k] = tx_w[7:0];
      end
      for (int k = 0; k < 2; k++) begin
         chk("overflow", 16'(ov[k]), 16'(data_rdata));
         pulse(data_rd);
         @(negedge sys_clk);
      end
      chk("overflow empty", 16'h0000, 16'(receive_complete_flag));
      wrap_up();
   end
endmodule
